//--- hdl/link_loss_policy.v
// Ethernet link-loss response policy with Avalon-MM register slave
//
// Behaviour
// R01: Codes 0-3: port one own, port two extended
// R02: Extended 0 ignores port two loss
// R03: Extended 1 port two gives warning only
// R04: Extended 2 port two warning plus alarm
// R05: Extended 3 port two loss trips
// R06: 8888 applies port one action on both-loss
// R07: 9999 default applies action on either loss
// R08: No trip while stopped or resetting
// R09: Cyclic fieldbus loss always trips; code latches no fault while driveResetting, since drive reset clears it first
// R10: Trip stops drive by comm stop mode
// R11: Relay select takes 0 or 9999, resets 0
// R12: Duplicate slot codes: lowest slot wins
// R13: Code 34962 in any slot disables diagnosis
// R14: Tool uses 5001 UDP or 5002 TCP
// R15: Four gateway bytes route off-net traffic
// R16: Relay 0 forwards through reset, 9999 stops
// R17: Speed or address change stops forwarding
// R18: Per-port loss from link status, then combined
`timescale 1ns/100ps
`include "link_loss_map.vh"

module link_loss_policy #(
   parameter SLOTS = 4
) (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Avalon-MM slave
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   output reg [1:0] response,
   // Drive and link status
   input wire port1LinkUp,
   input wire port2LinkUp,
   input wire driveStopped,
   input wire driveResetting,
   input wire cyclicActive,
   input wire [1:0] commErrorStopMode,
   // Policy outputs
   output reg linkLossWarning,
   output reg alarmOutput,
   output reg linkLossFault,
   output reg [1:0] faultStopMode,
   output reg relayEnable,
   output reg networkDiagEnable,
   output reg [SLOTS-1:0] slotValid,
   output reg [31:0] gatewayAddr,
   output reg irq
);

   // ==========================================================
   // Settings
   reg [15:0] port1LossAction;
   reg [15:0] port2LossActionExt;
   reg [15:0] relayOnResetSelect;
   reg [15:0] networkDiagSelect;
   reg [16*SLOTS-1:0] functionSlots;
   reg [2:0] irqStatus;
   reg [2:0] irqMask;
   reg forwardHold;
   reg [31:0] next_readdata;
   reg [1:0] next_response;
   wire [31:0] act1Merged;

   // Byte-lane merge for partial writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0] be;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (be[k])
               merge[k*8 +: 8] = wd[k*8 +: 8];
         end
      end
   endfunction

   // Map a setting to warn/alarm/trip responses
   function [2:0] actionOf;
      input [15:0] code;
      begin
         case (code)
            `LOSS_WARN: actionOf = 3'b001;
            `LOSS_ALARM: actionOf = 3'b011;
            `LOSS_TRIP: actionOf = 3'b100;
            default: actionOf = 3'b000;
         endcase
      end
   endfunction

   // ==========================================================
   // Loss combination
   wire loss1 = ~port1LinkUp; // R18
   wire loss2 = ~port2LinkUp; // R18
   wire [2:0] act1 = actionOf(port1LossAction);
   wire [2:0] act2 = actionOf(port2LossActionExt);
   reg [2:0] lossAct;
   always @* begin
      if (port2LossActionExt == `LOSS_BOTH) begin
         lossAct = (loss1 & loss2) ? act1 : 3'b000; // R06
      end else if (port2LossActionExt == `LOSS_EITHER) begin
         lossAct = (loss1 | loss2) ? act1 : 3'b000; // R07
      end else begin
         // Extended 0 yields no action for port two
         lossAct = (loss1 ? act1 : 3'b000) | (loss2 ? act2 : 3'b000); // R01 R02 R03 R04 R05
      end
   end
   // Trip is blocked while the drive is idle, except cyclic fieldbus traffic
   wire tripNow = ((lossAct[2] & ~driveStopped & ~driveResetting)
                  | (cyclicActive & (loss1 | loss2))); // R08 R09

   // ==========================================================
   // Slot priority and code decode
   reg [SLOTS-1:0] next_valid;
   reg diagBlock;
   reg toolSeen;
   integer i;
   integer j;
   always @* begin
      next_valid = {SLOTS{1'b1}};
      diagBlock = 1'b0;
      toolSeen = 1'b0;
      for (i = 0; i < SLOTS; i = i + 1) begin
         if (functionSlots[i*16 +: 16] == `CODE_UNSEL)
            next_valid[i] = 1'b0;
         for (j = 0; j < i; j = j + 1) begin
            if (functionSlots[i*16 +: 16] == functionSlots[j*16 +: 16])
               next_valid[i] = 1'b0; // R12
         end
         if (functionSlots[i*16 +: 16] == `CODE_NODIAG)
            diagBlock = 1'b1; // R13
         if (functionSlots[i*16 +: 16] == `CODE_TOOL_UDP ||
             functionSlots[i*16 +: 16] == `CODE_TOOL_TCP)
            toolSeen = 1'b1; // R14
      end
   end

   // ==========================================================
   // Outputs and fault latch
   always @(posedge core_clk) begin
      if (srst) begin
         linkLossWarning <= 1'b0;
         alarmOutput <= 1'b0;
         linkLossFault <= 1'b0;
         faultStopMode <= 2'h0;
         relayEnable <= 1'b1;
         networkDiagEnable <= 1'b1;
         slotValid <= {SLOTS{1'b0}};
         gatewayAddr <= `RST_GATEWAY;
      end else begin
         linkLossWarning <= lossAct[0];
         alarmOutput <= lossAct[1];
         // Fault holds until a drive reset clears it
         if (driveResetting)
            linkLossFault <= 1'b0;
         else if (tripNow) begin
            linkLossFault <= 1'b1;
            faultStopMode <= commErrorStopMode; // R10
         end
         relayEnable <= ~forwardHold &
            ~(driveResetting & (relayOnResetSelect == `RELAY_STOP)); // R16 R17
         networkDiagEnable <= ~diagBlock & (networkDiagSelect != 16'h0000); // R13
         slotValid <= next_valid;
         gatewayAddr <= gatewayReg; // R15
      end
   end

   // ==========================================================
   // Avalon slave: one wait cycle, then the answer
   wire acc = (read | write) & waitrequest;
   wire wrDo = write & ~waitrequest;
   reg [31:0] gatewayReg;
   reg [2:0] irqEvt;
   always @* begin
      irqEvt[`IRQ_WARN] = lossAct[0] & ~linkLossWarning;
      irqEvt[`IRQ_TRIP] = tripNow & ~linkLossFault;
      irqEvt[`IRQ_RELAYSTOP] = relayEnable & forwardHold;
   end

   always @(posedge core_clk) begin
      if (srst) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
         response <= 2'h0;
         port1LossAction <= `RST_PORT1_ACTION;
         port2LossActionExt <= `RST_PORT2_EXT;
         relayOnResetSelect <= `RST_RELAY_SEL; // R11
         networkDiagSelect <= `RST_DIAG_SEL;
         functionSlots <= {`RST_SLOT3, `RST_SLOT2, `RST_SLOT1, `RST_SLOT0}; // R14
         gatewayReg <= `RST_GATEWAY;
         irqStatus <= 3'h0;
         irqMask <= 3'h0;
         forwardHold <= 1'b0;
         irq <= 1'b0;
      end else begin
         waitrequest <= ~acc;
         readdata <= next_readdata;
         response <= next_response;
         // Event set wins over write-one-to-clear
         irqStatus <= (irqStatus & ~((wrDo && address == `OFS_IRQ_STATUS) ?
            writedata[2:0] : 3'h0)) | irqEvt;
         // A set mask bit hides its status bit from the line
         irq <= |(irqStatus & ~irqMask);
         if (wrDo) begin
            if (address == `OFS_PORT1_ACTION) begin
               port1LossAction <= act1Merged[15:0];
            end else if (address == `OFS_PORT2_EXT) begin
               port2LossActionExt <= writedata[15:0];
            end else if (address == `OFS_RELAY_SEL) begin
               // Only the two legal codes are accepted
               if (writedata[15:0] == `RELAY_KEEP || writedata[15:0] == `RELAY_STOP)
                  relayOnResetSelect <= writedata[15:0]; // R11
            end else if (address == `OFS_DIAG_SEL) begin
               networkDiagSelect <= writedata[15:0];
            end else if (address == `OFS_SLOT0) begin
               functionSlots[15:0] <= writedata[15:0];
            end else if (address == `OFS_SLOT1) begin
               functionSlots[31:16] <= writedata[15:0];
            end else if (address == `OFS_SLOT2) begin
               functionSlots[47:32] <= writedata[15:0];
            end else if (address == `OFS_SLOT3) begin
               functionSlots[63:48] <= writedata[15:0];
            end else if (address == `OFS_GATEWAY) begin
               gatewayReg <= merge(gatewayReg, writedata, byteenable); // R15
            end else if (address == `OFS_IRQ_MASK) begin
               irqMask <= writedata[2:0];
            end else if (address == `OFS_CHANGE) begin
               // Bit0 set: speed/duplex or IP changed; bit1 set: release
               if (writedata[0])
                  forwardHold <= 1'b1; // R17
               else if (writedata[1])
                  forwardHold <= 1'b0;
            end
         end
      end
   end

   // Byte-lane merge of the port one action, low half kept
   assign act1Merged = merge({16'h0000, port1LossAction}, writedata, byteenable);

   // Read mux
   always @* begin
      next_readdata = 32'h00000000;
      next_response = 2'h0;
      if (read & waitrequest) begin
         if (address == `OFS_PORT1_ACTION)
            next_readdata = {16'h0000, port1LossAction};
         else if (address == `OFS_PORT2_EXT)
            next_readdata = {16'h0000, port2LossActionExt};
         else if (address == `OFS_RELAY_SEL)
            next_readdata = {16'h0000, relayOnResetSelect};
         else if (address == `OFS_DIAG_SEL)
            next_readdata = {16'h0000, networkDiagSelect};
         else if (address == `OFS_SLOT0)
            next_readdata = {16'h0000, functionSlots[15:0]};
         else if (address == `OFS_SLOT1)
            next_readdata = {16'h0000, functionSlots[31:16]};
         else if (address == `OFS_SLOT2)
            next_readdata = {16'h0000, functionSlots[47:32]};
         else if (address == `OFS_SLOT3)
            next_readdata = {16'h0000, functionSlots[63:48]};
         else if (address == `OFS_GATEWAY)
            next_readdata = gatewayReg;
         else if (address == `OFS_SLOT_VALID)
            next_readdata = {{(32-SLOTS){1'b0}}, slotValid};
         else if (address == `OFS_STATUS)
            next_readdata = {24'h000000, loss2, loss1, toolSeen, networkDiagEnable,
               relayEnable, linkLossFault, alarmOutput, linkLossWarning};
         else if (address == `OFS_IRQ_STATUS)
            next_readdata = {29'h00000000, irqStatus};
         else if (address == `OFS_IRQ_MASK)
            next_readdata = {29'h00000000, irqMask};
         else if (address == `OFS_CHANGE)
            next_readdata = {31'h00000000, forwardHold};
         else
            next_response = 2'h2; // Unmapped: slave error
      end else if (write & waitrequest) begin
         // Unaligned or past the last register: slave error
         if (address > `OFS_CHANGE || address[1:0] != 2'b00)
            next_response = 2'h2;
      end
   end
endmodule

//--- common/link_loss_map.vh
// Constants for the Ethernet link-loss policy block: offsets, fields, resets, codes
`ifndef LINK_LOSS_MAP_VH
`define LINK_LOSS_MAP_VH
// ==========================================================
// Register byte offsets
`define OFS_PORT1_ACTION 8'h00
`define OFS_PORT2_EXT 8'h04
`define OFS_RELAY_SEL 8'h08
`define OFS_DIAG_SEL 8'h0c
`define OFS_SLOT0 8'h10
`define OFS_SLOT1 8'h14
`define OFS_SLOT2 8'h18
`define OFS_SLOT3 8'h1c
`define OFS_GATEWAY 8'h20
`define OFS_SLOT_VALID 8'h24
`define OFS_STATUS 8'h28
`define OFS_IRQ_STATUS 8'h2c
`define OFS_IRQ_MASK 8'h30
`define OFS_CHANGE 8'h34
// ==========================================================
// Setting codes
`define LOSS_OFF 16'h0000
`define LOSS_WARN 16'h0001
`define LOSS_ALARM 16'h0002
`define LOSS_TRIP 16'h0003
`define LOSS_BOTH 16'h22b8
`define LOSS_EITHER 16'h270f
`define RELAY_KEEP 16'h0000
`define RELAY_STOP 16'h270f
`define CODE_NODIAG 16'h8892
`define CODE_TOOL_UDP 16'h1389
`define CODE_TOOL_TCP 16'h138a
`define CODE_UNSEL 16'h270f
// ==========================================================
// Reset values
`define RST_PORT1_ACTION 16'h0003
`define RST_PORT2_EXT 16'h270f
`define RST_RELAY_SEL 16'h0000
`define RST_DIAG_SEL 16'h270f
`define RST_SLOT0 16'h1389
`define RST_SLOT1 16'hb0b5
`define RST_SLOT2 16'hb0b6
`define RST_SLOT3 16'h270f
`define RST_GATEWAY 32'h00000000
// ==========================================================
// Status and interrupt bit positions
`define ST_WARN 0
`define ST_ALARM 1
`define ST_TRIP 2
`define ST_RELAY 3
`define ST_DIAG 4
`define ST_TOOL 5
`define ST_LOSS1 6
`define ST_LOSS2 7
`define IRQ_WIDTH 3
`define IRQ_WARN 0
`define IRQ_TRIP 1
`define IRQ_RELAYSTOP 2
`endif

//--- bench/link_peer.sv
// Far-side station model: drives each port's link status from a cable state
`timescale 1ns/100ps
module link_peer (
   // Clock
   input wire core_clk,
   // Cable cut requests from the bench
   input wire cut1,
   input wire cut2,
   // Link status seen by the device
   output reg link1Up,
   output reg link2Up
);
   // ==========================================
   // Link status
   // Registered, so a cut looks like a PHY dropping link and never a glitch
   always @(posedge core_clk) begin
      link1Up <= ~cut1;
      link2Up <= ~cut2;
   end
endmodule

//--- bench/link_loss_policy_sva.sv
// Assertion checker for the link-loss policy block
`timescale 1ns/100ps
module link_loss_policy_sva (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Register bus
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire waitrequest,
   input wire [1:0] response,
   // Drive and link status
   input wire port1LinkUp,
   input wire port2LinkUp,
   input wire driveStopped,
   input wire driveResetting,
   input wire cyclicActive,
   input wire [1:0] commErrorStopMode,
   // Policy outputs
   input wire linkLossWarning,
   input wire alarmOutput,
   input wire linkLossFault,
   input wire [1:0] faultStopMode
);
   // ==========================================
   // One clock domain; reset masks every check
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   // ==========================================
   // Bus handshake
   AST_TAKE: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one cycle");
   AST_ONE_CYCLE: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   // Unaligned or past the last register answers as unmapped
   AST_RESP: assert property ($fell(waitrequest) |-> response ==
      ((($past(address) > 8'h34) || (($past(address) & 8'h03) != 8'h00)) ? 2'b10 : 2'b00))
      else $error("wrong response code");

   // ==========================================
   // Loss policy
   AST_NO_LOSS: assert property (
      (port1LinkUp && port2LinkUp) [*5] |-> !linkLossWarning && !alarmOutput)
      else $error("indication with both links up");
   AST_ALARM_WARN: assert property (
      alarmOutput && !linkLossFault |-> linkLossWarning)
      else $error("alarm without warning");
   AST_SUPPRESS: assert property (driveResetting [*2] |-> !linkLossFault)
      else $error("fault held during drive reset");
   AST_STICKY: assert property (linkLossFault && !driveResetting |=> linkLossFault)
      else $error("fault dropped without drive reset");
   AST_STOP_MODE: assert property (
      $rose(linkLossFault) |-> faultStopMode == $past(commErrorStopMode))
      else $error("stop mode not taken at trip");
   // Cyclic traffic overrides both settings
   AST_CYCLIC: assert property (
      (cyclicActive && !port2LinkUp && !driveStopped && !driveResetting) [*5]
      |-> linkLossFault)
      else $error("no trip on loss during cyclic exchange");
endmodule

bind link_loss_policy link_loss_policy_sva i_link_loss_policy_sva (
   .core_clk(core_clk), .srst(srst), .address(address), .read(read), .write(write),
   .waitrequest(waitrequest), .response(response), .port1LinkUp(port1LinkUp),
   .port2LinkUp(port2LinkUp), .driveStopped(driveStopped), .driveResetting(driveResetting),
   .cyclicActive(cyclicActive), .commErrorStopMode(commErrorStopMode),
   .linkLossWarning(linkLossWarning), .alarmOutput(alarmOutput),
   .linkLossFault(linkLossFault), .faultStopMode(faultStopMode));

//--- bench/link_loss_policy_tb.sv
// Self-checking bench for the link-loss policy block
`timescale 1ns/100ps
`include "link_loss_map.vh"
module link_loss_policy_tb;
   // ==========================================
   // Stimulus and observed signals
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic cut1 = 1'b0;
   logic cut2 = 1'b0;
   logic driveStopped = 1'b0;
   logic driveResetting = 1'b0;
   logic cyclicActive = 1'b0;
   logic [1:0] commErrorStopMode = 2'h2;
   logic [31:0] readdata, q, gatewayAddr;
   logic [1:0] response, resp, faultStopMode;
   logic waitrequest, port1LinkUp, port2LinkUp, linkLossWarning, alarmOutput, linkLossFault;
   logic relayEnable, networkDiagEnable, irq;
   logic [3:0] slotValid;
   int numErrors = 0;
   int checksDone = 0;
   // Rows: settings, link state, expected {fault, alarm, warning} under a mask
   typedef struct packed {
      logic [15:0] ext;
      logic [15:0] act;
      logic up1;
      logic up2;
      logic [2:0] exp;
      logic [2:0] msk;
   } row_t;
   row_t rows [10] = '{
      '{`LOSS_OFF, `LOSS_WARN, 1'b1, 1'b0, 3'h0, 3'h7},
      '{`LOSS_WARN, `LOSS_OFF, 1'b1, 1'b0, 3'h1, 3'h7},
      '{`LOSS_ALARM, `LOSS_OFF, 1'b1, 1'b0, 3'h3, 3'h7},
      '{`LOSS_TRIP, `LOSS_OFF, 1'b1, 1'b0, 3'h4, 3'h4},
      '{`LOSS_TRIP, `LOSS_OFF, 1'b0, 1'b1, 3'h0, 3'h7},
      '{`LOSS_WARN, `LOSS_ALARM, 1'b0, 1'b1, 3'h3, 3'h7},
      '{`LOSS_BOTH, `LOSS_WARN, 1'b0, 1'b1, 3'h0, 3'h7},
      '{`LOSS_BOTH, `LOSS_WARN, 1'b0, 1'b0, 3'h1, 3'h7},
      '{`LOSS_EITHER, `LOSS_ALARM, 1'b1, 1'b0, 3'h3, 3'h7},
      '{`LOSS_EITHER, `LOSS_TRIP, 1'b0, 1'b1, 3'h4, 3'h4}};

   // ==========================================
   // Clock, far side and device
   always #10 core_clk = ~core_clk;
   link_peer i_link_peer (.core_clk(core_clk), .cut1(cut1), .cut2(cut2),
      .link1Up(port1LinkUp), .link2Up(port2LinkUp));
   link_loss_policy i_link_loss_policy (.core_clk(core_clk), .srst(srst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
      .readdata(readdata), .waitrequest(waitrequest), .response(response),
      .port1LinkUp(port1LinkUp), .port2LinkUp(port2LinkUp), .driveStopped(driveStopped),
      .driveResetting(driveResetting), .cyclicActive(cyclicActive),
      .commErrorStopMode(commErrorStopMode), .linkLossWarning(linkLossWarning),
      .alarmOutput(alarmOutput), .linkLossFault(linkLossFault),
      .faultStopMode(faultStopMode), .relayEnable(relayEnable),
      .networkDiagEnable(networkDiagEnable), .slotValid(slotValid),
      .gatewayAddr(gatewayAddr), .irq(irq));

   // ==========================================
   // Tasks
   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Holds the request until waitrequest is sampled low, bounded in case it never is
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      q = readdata;
      resp = response;
      if (n >= 50) numErrors++;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic reportAndStop;
      if (numErrors == 0 && checksDone > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Clears a sticky fault; only a drive reset or srst gets out of it
   task automatic driveReset;
      cut1 <= 1'b0;
      cut2 <= 1'b0;
      driveResetting <= 1'b1;
      ticks(3);
      driveResetting <= 1'b0;
      ticks(2);
   endtask

   // ==========================================
   // Watchdog, well beyond the expected run
   initial begin
      #400000;
      numErrors++;
      reportAndStop;
   end

   // ==========================================
   // Main sequence
   initial begin
      ticks(8);
      srst <= 1'b0;
      foreach (rows[i]) begin
         bus(1'b1, `OFS_PORT2_EXT, {16'h0, rows[i].ext});
         bus(1'b1, `OFS_PORT1_ACTION, {16'h0, rows[i].act});
         cut1 <= ~rows[i].up1;
         cut2 <= ~rows[i].up2;
         ticks(6);
         chk("policy", 32'(rows[i].exp),
            32'(rows[i].msk & {linkLossFault, alarmOutput, linkLossWarning}));
         driveReset;
      end
      // Mid-run reset brings back the documented defaults
      srst <= 1'b1;
      ticks(8);
      srst <= 1'b0;
      chk("relay", 32'h1, 32'(relayEnable));
      bus(1'b0, `OFS_PORT1_ACTION, 32'h0);
      chk("port1 action", `RST_PORT1_ACTION, q);
      bus(1'b0, `OFS_PORT2_EXT, 32'h0);
      chk("ext action", `RST_PORT2_EXT, q);
      bus(1'b0, `OFS_SLOT0, 32'h0);
      chk("slot one", `CODE_TOOL_UDP, q);
      // Relay select refuses other codes; reset behaviour follows it
      bus(1'b1, `OFS_RELAY_SEL, 32'h5);
      bus(1'b0, `OFS_RELAY_SEL, 32'h0);
      chk("relay sel", `RELAY_KEEP, q);
      bus(1'b1, `OFS_RELAY_SEL, `RELAY_STOP);
      driveResetting <= 1'b1;
      ticks(3);
      chk("relay", 32'h0, 32'(relayEnable));
      bus(1'b1, `OFS_RELAY_SEL, `RELAY_KEEP);
      ticks(2);
      chk("relay", 32'h1, 32'(relayEnable));
      driveResetting <= 1'b0;
      bus(1'b1, `OFS_CHANGE, 32'h1);
      ticks(2);
      chk("relay", 32'h0, 32'(relayEnable));
      bus(1'b1, `OFS_CHANGE, 32'h2);
      // Slots: duplicate of slot one, then the diagnosis kill code
      bus(1'b1, `OFS_SLOT1, `CODE_TOOL_UDP);
      ticks(2);
      chk("slots", 32'h5, 32'(slotValid));
      bus(1'b1, `OFS_SLOT3, `CODE_NODIAG);
      ticks(2);
      chk("diag", 32'h0, 32'(networkDiagEnable));
      bus(1'b0, 8'h40, 32'h0);
      chk("response", 32'h2, 32'(resp));
      // Gateway bytes reach the routing output
      bus(1'b1, `OFS_GATEWAY, 32'h0a0b0c0d);
      ticks(2);
      chk("gateway", 32'h0a0b0c0d, gatewayAddr);
      bus(1'b0, `OFS_GATEWAY, 32'h0);
      chk("gateway read", 32'h0a0b0c0d, q);
      // Trip held off while stopped, then raised, masked and cleared
      bus(1'b1, `OFS_IRQ_MASK, 32'h0);
      bus(1'b1, `OFS_IRQ_STATUS, 32'h7);
      driveStopped <= 1'b1;
      cut1 <= 1'b1;
      ticks(6);
      chk("fault", 32'h0, 32'(linkLossFault));
      driveStopped <= 1'b0;
      ticks(6);
      chk("fault", 32'h1, 32'(linkLossFault));
      chk("stop mode", 32'h2, 32'(faultStopMode));
      chk("irq", 32'h1, 32'(irq));
      bus(1'b1, `OFS_IRQ_MASK, 32'h7);
      ticks(2);
      chk("irq", 32'h0, 32'(irq));
      driveReset;
      bus(1'b1, `OFS_IRQ_STATUS, 32'h7);
      bus(1'b1, `OFS_IRQ_MASK, 32'h0);
      ticks(2);
      chk("irq", 32'h0, 32'(irq));
      // Cyclic exchange trips whatever the settings say
      bus(1'b1, `OFS_PORT1_ACTION, `LOSS_OFF);
      bus(1'b1, `OFS_PORT2_EXT, `LOSS_OFF);
      cyclicActive <= 1'b1;
      cut2 <= 1'b1;
      ticks(6);
      chk("fault", 32'h1, 32'(linkLossFault));
      reportAndStop;
   end
endmodule
